// ===== pif_pkg.sv
// package for the peripheral interrupt flag block: offsets, bit positions, resets
// assumes a 32-bit apb slave with word-aligned registers
package pif_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] PIF_OFS_FLAGS   = 12'h0_000; // peripheral_irq_flags_1
  localparam logic [11:0] PIF_OFS_RXBUF   = 12'h0_004; // serial_rx_buffer
  localparam logic [11:0] PIF_OFS_TXBUF   = 12'h0_008; // serial_tx_buffer
  localparam logic [11:0] PIF_OFS_IRQ_ST  = 12'h0_00C; // sticky event status, w1c
  localparam logic [11:0] PIF_OFS_IRQ_MSK = 12'h0_010; // event mask

  // ----------------------------------------------------------------------
  // flag bit positions
  // ----------------------------------------------------------------------
  localparam int PIF_BIT_PARALLEL  = 7;
  localparam int PIF_BIT_CONVERTER = 6;
  localparam int PIF_BIT_SER_RX    = 5;
  localparam int PIF_BIT_SER_TX    = 4;
  localparam int PIF_BIT_SYNC      = 3;
  localparam int PIF_BIT_TIMER_B   = 1;
  localparam int PIF_BIT_TIMER_A   = 0;

  localparam logic [7:0]  PIF_SW_MASK    = 8'hCB; // bits software writes directly
  localparam logic [7:0]  PIF_IMPL_MASK  = 8'hFB; // bit 2 unimplemented
  localparam logic [7:0]  PIF_FLAG_RESET = 8'h00;
  localparam logic [7:0]  PIF_VIEW_RESET = 8'h10; // flag view out of reset: tx buffer empty
  localparam logic [7:0]  PIF_BYTE_ZERO  = 8'h00;
  localparam logic [31:0] PIF_WORD_ZERO  = 32'h0000_0000;

  // event pulses from peripheral logic, one cycle each
  typedef struct packed {
    logic parallel_access;
    logic converter_done;
    logic sync_serial_done;
    logic timer_b_match;
    logic timer_a_overflow;
  } pif_events_t;

  // serial receive buffer side
  typedef struct packed {
    logic       rx_load;
    logic [7:0] rx_byte;
  } pif_rx_in_t;

endpackage : pif_pkg

// ===== pif_flags.sv
// peripheral interrupt flag register with apb access and a summary interrupt
// assumes event pulses and rx/tx handshakes come from logic on pclk
//
// What this block does
// - flags set on their event regardless of any enable bit
// - bit 6 set on conversion done, held until software writes zero
// - bit 5 read-only, set while rx buffer full, cleared by buffer read
// - bit 4 read-only, set while tx buffer empty, cleared by buffer write
// - bit 3 set on sync serial completion, cleared only by software
// - bit 2 unimplemented, reads zero, ignores writes
// - bit 1 set on timer-b match with period, held until cleared
// - bit 0 set on timer-a overflow, held until cleared
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps

module pif_flags
  import pif_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // peripheral events
  input  wire pif_events_t events,
  input  wire pif_rx_in_t  rx_in,
  input  wire logic        tx_drained,
  // peripheral side of the serial buffers
  output logic      [7:0]  tx_byte,
  output logic             tx_load,
  // flag view and interrupt
  output logic      [7:0]  flags,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PIF_SEL_FLAGS = 3'b001,
    PIF_SEL_BUF   = 3'b010,
    PIF_SEL_IRQ   = 3'b100
  } pif_sel_t;

  logic acc;
  logic wr;
  logic rd;
  logic mapped;

  // every access completes in its first access cycle
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == PIF_OFS_FLAGS) | (paddr == PIF_OFS_RXBUF) |
                   (paddr == PIF_OFS_TXBUF) | (paddr == PIF_OFS_IRQ_ST) |
                   (paddr == PIF_OFS_IRQ_MSK);
  assign pslverr = acc & ~mapped;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  pif_sel_t sel;
  always_comb begin
    sel = PIF_SEL_FLAGS;
    if (hit(paddr, PIF_OFS_RXBUF) | hit(paddr, PIF_OFS_TXBUF)) begin
      sel = PIF_SEL_BUF;
    end else if (hit(paddr, PIF_OFS_IRQ_ST) | hit(paddr, PIF_OFS_IRQ_MSK)) begin
      sel = PIF_SEL_IRQ;
    end
  end

  // ----------------------------------------------------------------------
  // flag register and serial buffers
  // ----------------------------------------------------------------------
  logic [7:0] flag_q, flag_d;
  logic       rx_full_q, rx_full_d;
  logic       tx_empty_q, tx_empty_d;
  logic [7:0] rx_buf_q, rx_buf_d;
  logic [7:0] tx_buf_q, tx_buf_d;
  logic       tx_load_q, tx_load_d;
  logic       rx_read;
  logic       tx_write;
  logic [7:0] hw_set;

  assign rx_read  = rd & hit(paddr, PIF_OFS_RXBUF);
  assign tx_write = wr & hit(paddr, PIF_OFS_TXBUF);

  // hardware sets ignore every enable bit, which lives elsewhere
  always_comb begin
    hw_set                    = PIF_BYTE_ZERO;
    hw_set[PIF_BIT_PARALLEL]  = events.parallel_access;
    hw_set[PIF_BIT_CONVERTER] = events.converter_done;
    hw_set[PIF_BIT_SYNC]      = events.sync_serial_done;
    hw_set[PIF_BIT_TIMER_B]   = events.timer_b_match;
    hw_set[PIF_BIT_TIMER_A]   = events.timer_a_overflow;
  end

  // next state; a flag set or rx load in the clear cycle wins so neither is lost; a tx buffer write beats a drain
  always_comb begin
    flag_d     = flag_q;
    rx_full_d  = rx_full_q;
    tx_empty_d = tx_empty_q;
    rx_buf_d   = rx_buf_q;
    tx_buf_d   = tx_buf_q;
    tx_load_d  = 1'b0;
    if (wr & hit(paddr, PIF_OFS_FLAGS)) begin
      flag_d = (flag_q & ~PIF_SW_MASK) | (pwdata[7:0] & PIF_SW_MASK);
    end
    flag_d = (flag_d | hw_set) & PIF_SW_MASK;
    // receive flag mirrors buffer fullness
    if (rx_read) begin
      rx_full_d = 1'b0;
    end
    if (rx_in.rx_load) begin
      rx_full_d = 1'b1;
      rx_buf_d  = rx_in.rx_byte;
    end
    // transmit flag mirrors buffer emptiness
    if (tx_drained) begin
      tx_empty_d = 1'b1;
    end
    if (tx_write) begin
      tx_empty_d = 1'b0;
      tx_buf_d   = pwdata[7:0];
      tx_load_d  = 1'b1;
    end
  end

  // tx buffer starts empty, so its flag reads one after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q     <= PIF_FLAG_RESET;
      rx_full_q  <= 1'b0;
      tx_empty_q <= 1'b1;
      rx_buf_q   <= PIF_BYTE_ZERO;
      tx_buf_q   <= PIF_BYTE_ZERO;
      tx_load_q  <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      rx_full_q  <= rx_full_d;
      tx_empty_q <= tx_empty_d;
      rx_buf_q   <= rx_buf_d;
      tx_buf_q   <= tx_buf_d;
      tx_load_q  <= tx_load_d;
    end
  end

  always_comb begin
    flags                 = flag_q;
    flags[PIF_BIT_SER_RX] = rx_full_q;
    flags[PIF_BIT_SER_TX] = tx_empty_q;
  end
  assign tx_byte = tx_buf_q;
  assign tx_load = tx_load_q;

  // ----------------------------------------------------------------------
  // sticky status, mask and interrupt
  // ----------------------------------------------------------------------
  logic [7:0] st_q, st_d;
  logic [7:0] msk_q, msk_d;
  logic [7:0] rise;
  logic [7:0] flags_prev_q;

  // level flags rx/tx count as events when they rise
  assign rise = flags & ~flags_prev_q;

  always_comb begin
    st_d  = st_q;
    msk_d = msk_q;
    if (wr & hit(paddr, PIF_OFS_IRQ_ST)) begin
      st_d = st_q & ~pwdata[7:0];
    end
    if (wr & hit(paddr, PIF_OFS_IRQ_MSK)) begin
      msk_d = pwdata[7:0] & PIF_IMPL_MASK;
    end
    st_d = (st_d | rise | hw_set) & PIF_IMPL_MASK;
  end

  // edge history starts at the reset view, so the empty tx buffer is no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= PIF_BYTE_ZERO;
      msk_q        <= PIF_BYTE_ZERO;
      flags_prev_q <= PIF_VIEW_RESET;
    end else begin
      st_q         <= st_d;
      msk_q        <= msk_d;
      flags_prev_q <= flags;
    end
  end

  assign irq = |(st_q & msk_q);

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = PIF_WORD_ZERO;
    unique case (sel)
      PIF_SEL_FLAGS: begin
        if (hit(paddr, PIF_OFS_FLAGS)) begin
          rdata[7:0] = flags & PIF_IMPL_MASK;
        end
      end
      PIF_SEL_BUF: begin
        rdata[7:0] = hit(paddr, PIF_OFS_RXBUF) ? rx_buf_q : tx_buf_q;
      end
      PIF_SEL_IRQ: begin
        rdata[7:0] = hit(paddr, PIF_OFS_IRQ_ST) ? st_q : msk_q;
      end
    endcase
  end
  // combinational read is legal since pready is high in the access phase
  assign prdata = rd ? rdata : PIF_WORD_ZERO;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_conv_sets: assert property (events.converter_done |=> flags[PIF_BIT_CONVERTER])
    else $error("converter flag not set");
  a_conv_holds: assert property (flags[PIF_BIT_CONVERTER] &&
      !(wr && paddr == PIF_OFS_FLAGS) |=> flags[PIF_BIT_CONVERTER])
    else $error("converter flag dropped without write");
  a_rx_clear: assert property (rx_read && !rx_in.rx_load |=> !flags[PIF_BIT_SER_RX])
    else $error("rx flag not cleared by buffer read");
  a_rx_set: assert property (rx_in.rx_load |=> flags[PIF_BIT_SER_RX])
    else $error("rx flag not set on load");
  a_tx_clear: assert property (tx_write |=> !flags[PIF_BIT_SER_TX] && tx_load)
    else $error("tx flag not cleared by buffer write");
  a_sync_sets: assert property (events.sync_serial_done |=> flags[PIF_BIT_SYNC])
    else $error("sync flag not set");
  a_bit2_zero: assert property ((flags & ~PIF_IMPL_MASK) == PIF_BYTE_ZERO &&
      (!(rd && hit(paddr, PIF_OFS_FLAGS)) || (prdata[7:0] & ~PIF_IMPL_MASK) == PIF_BYTE_ZERO))
    else $error("bit 2 not zero");
  a_timer_b: assert property (events.timer_b_match |=> flags[PIF_BIT_TIMER_B])
    else $error("timer b flag not set");
  a_timer_a: assert property (events.timer_a_overflow ##1 !events.timer_a_overflow
      && !wr |=> flags[PIF_BIT_TIMER_A])
    else $error("timer a flag not held");
  a_parallel: assert property (events.parallel_access |=> flags[PIF_BIT_PARALLEL])
    else $error("parallel flag not set");
  a_sw_write: assert property (wr && paddr == PIF_OFS_FLAGS && !pwdata[PIF_BIT_SYNC]
      && !events.sync_serial_done |=> !flags[PIF_BIT_SYNC])
    else $error("software clear ignored");
  // an unmasked event must reach the pin the cycle after it
  a_irq_level: assert property ((|(hw_set & msk_q)) &&
      !(wr && hit(paddr, PIF_OFS_IRQ_MSK)) |=> irq)
    else $error("unmasked event raised no interrupt");

  // ----------------------------------------------------------------------
  // checks: holding, set against clear, serial flags, status and bus
  // ----------------------------------------------------------------------
  // software-clear bits survive every cycle without a flag write
  a_sync_holds: assert property (flags[PIF_BIT_SYNC] &&
      !(wr && hit(paddr, PIF_OFS_FLAGS)) |=> flags[PIF_BIT_SYNC])
    else $error("sync flag dropped without write");
  a_timer_b_holds: assert property (flags[PIF_BIT_TIMER_B] &&
      !(wr && hit(paddr, PIF_OFS_FLAGS)) |=> flags[PIF_BIT_TIMER_B])
    else $error("timer b flag dropped without write");
  a_timer_a_holds: assert property (flags[PIF_BIT_TIMER_A] &&
      !(wr && hit(paddr, PIF_OFS_FLAGS)) |=> flags[PIF_BIT_TIMER_A])
    else $error("timer a flag dropped without write");
  a_parallel_holds: assert property (flags[PIF_BIT_PARALLEL] &&
      !(wr && hit(paddr, PIF_OFS_FLAGS)) |=> flags[PIF_BIT_PARALLEL])
    else $error("parallel flag dropped without write");

  // an event in the clear cycle wins, so software never loses one
  a_conv_wins: assert property (events.converter_done &&
      wr && hit(paddr, PIF_OFS_FLAGS) |=> flags[PIF_BIT_CONVERTER])
    else $error("converter event lost to a clear");
  a_rx_wins: assert property (rx_read && rx_in.rx_load |=> flags[PIF_BIT_SER_RX])
    else $error("rx load lost to a buffer read");

  // serial flags move only with the buffers behind them
  a_rx_hold: assert property (flags[PIF_BIT_SER_RX] && !rx_read |=>
      flags[PIF_BIT_SER_RX])
    else $error("rx flag dropped without buffer read");
  a_tx_set: assert property (tx_drained && !tx_write |=> flags[PIF_BIT_SER_TX])
    else $error("tx flag not set on drain");
  a_tx_hold: assert property (flags[PIF_BIT_SER_TX] && !tx_write |=>
      flags[PIF_BIT_SER_TX])
    else $error("tx flag dropped without buffer write");
  // a stray load would make the peripheral send a stale byte
  a_tx_load_src: assert property (tx_load |-> $past(tx_write))
    else $error("tx load without buffer write");
  a_tx_byte: assert property (tx_write |=> tx_byte == 8'($past(pwdata)))
    else $error("tx byte differs from written data");

  // writes land as the bus carried them, masked to the software-writable bits
  a_flag_write: assert property (wr && hit(paddr, PIF_OFS_FLAGS) && !(|hw_set) |=>
      (flags & PIF_SW_MASK) == (8'($past(pwdata)) & PIF_SW_MASK))
    else $error("flag write did not land");
  // mask bit 2 stays clear so an unused bit can never hold the pin
  a_mask_write: assert property (wr && hit(paddr, PIF_OFS_IRQ_MSK) |=>
      msk_q == (8'($past(pwdata)) & PIF_IMPL_MASK))
    else $error("mask write did not land");

  // status and mask never hold the unimplemented bit
  a_status_bit2: assert property ((st_q & ~PIF_IMPL_MASK) == PIF_BYTE_ZERO &&
      (msk_q & ~PIF_IMPL_MASK) == PIF_BYTE_ZERO)
    else $error("bit 2 stored in status or mask");

  // status catches every event and clears only by a written one
  a_status_sets: assert property ((|hw_set) |=>
      (st_q & $past(hw_set)) == $past(hw_set))
    else $error("event missing from status");
  // a fresh event or rising level in the clear cycle keeps the bit, by design
  a_status_w1c: assert property (wr && hit(paddr, PIF_OFS_IRQ_ST) &&
      pwdata[PIF_BIT_CONVERTER] && !hw_set[PIF_BIT_CONVERTER] &&
      !rise[PIF_BIT_CONVERTER] |=> !st_q[PIF_BIT_CONVERTER])
    else $error("status bit not cleared by written one");
  // a masked event may set status but must never reach the pin
  a_irq_masked: assert property (msk_q == PIF_BYTE_ZERO |-> !irq)
    else $error("interrupt with every source masked");

  // refused addresses answer with an error and no data; idle reads are zero
  a_bad_addr: assert property (acc && !mapped |-> pslverr && prdata == PIF_WORD_ZERO)
    else $error("unmapped access not refused");
  a_read_idle: assert property (!rd |-> prdata == PIF_WORD_ZERO)
    else $error("read data outside a read");
  a_upper_zero: assert property (prdata[31:8] == PIF_WORD_ZERO[31:8])
    else $error("upper read data not zero");

  c_conv_irq: cover property (events.converter_done ##[1:20] irq);
  c_rx_cycle: cover property (rx_in.rx_load ##[1:20] rx_read);
  c_tx_cycle: cover property (tx_write ##[1:20] tx_drained);
  c_set_clear: cover property (wr && paddr == PIF_OFS_FLAGS && events.timer_a_overflow);
  c_mask_off: cover property (events.converter_done && !msk_q[PIF_BIT_CONVERTER]);

endmodule : pif_flags

// ===== pif_periph_model.sv
// peripheral event source model: event pulses, rx byte loads, tx drain
// assumes bench commands change just after pclk rising edges
`timescale 1ns/1ps

module pif_periph_model
  import pif_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench commands
  input  wire pif_events_t ev_cmd,
  input  wire pif_rx_in_t  rx_cmd,
  input  wire logic [3:0]  lag,
  // block side
  input  wire logic        tx_load,
  output pif_events_t      events,
  output pif_rx_in_t       rx_in,
  output logic             tx_drained
);
  // ----------------------------------------------------------------------
  // pulse sources
  // ----------------------------------------------------------------------
  logic [4:0] cnt_q;

  // idle rx byte flips so a stale byte never passes for fresh data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events     <= '0;
      rx_in      <= '0;
      tx_drained <= 1'b0;
      cnt_q      <= '0;
    end else begin
      events        <= ev_cmd;
      rx_in.rx_load <= rx_cmd.rx_load;
      rx_in.rx_byte <= rx_cmd.rx_load ? rx_cmd.rx_byte : ~rx_in.rx_byte;
      // drain lag lets the bench see the full tx buffer
      cnt_q         <= tx_load ? {1'b0, lag} + 5'h1 : cnt_q - {4'h0, (cnt_q != 5'h0)};
      tx_drained    <= (cnt_q == 5'h1);
    end
  end
endmodule : pif_periph_model

// ===== peripheral_irq_flag_register_tb.sv
// self-checking bench for the flag register, apb master and event model
// assumes pif_flags and pif_periph_model are compiled before it
`timescale 1ns/1ps

module peripheral_irq_flag_register_tb;
  import pif_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        tx_load, tx_drained, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  tx_byte, flags, v;
  logic [3:0]  lag;
  pif_events_t ev_cmd, events;
  pif_rx_in_t  rx_cmd, rx_in;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          pos [5] = '{PIF_BIT_TIMER_A, PIF_BIT_TIMER_B, PIF_BIT_SYNC,
                           PIF_BIT_CONVERTER, PIF_BIT_PARALLEL};

  pif_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .rx_in(rx_in), .tx_drained(tx_drained),
    .tx_byte(tx_byte), .tx_load(tx_load), .flags(flags), .irq(irq));
  pif_periph_model peer (.pclk(pclk), .presetn(presetn), .ev_cmd(ev_cmd), .rx_cmd(rx_cmd),
    .lag(lag), .tx_load(tx_load), .events(events), .rx_in(rx_in), .tx_drained(tx_drained));

  // expected flag view after a write with both serial buffers empty
  function automatic logic [7:0] wexp(input logic [7:0] w);
    return (w & PIF_SW_MASK) | 8'h10;
  endfunction : wexp

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, x);
    end
  endtask : chk

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fire(input pif_events_t ev, input pif_rx_in_t rx);
    @(posedge pclk);
    ev_cmd <= ev;
    rx_cmd <= rx;
    @(posedge pclk);
    ev_cmd <= '0;
    rx_cmd <= '0;
    repeat (3) @(posedge pclk);
  endtask : fire

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // hang guard well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ev_cmd = '0;
    rx_cmd = '0;
    lag    = 4'h0;
    v      = 8'($urandom(32'h879a));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h10);
    apb(1'b1, PIF_OFS_FLAGS, 0);
    // each event source with its mask off
    for (int i = 0; i < 5; i++) begin
      fire(pif_events_t'(1 << i), '0);
      repeat (10) @(posedge pclk);
      apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd[7:0], 8'h10 | (8'h1 << pos[i]));
      chk(irq, 0);
      apb(1'b1, PIF_OFS_FLAGS, 0);
      apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h10);
    end
    // direct writes, all ones and the unimplemented bit first
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 8'hFF : (k == 1) ? 8'h04 : 8'($urandom);
      apb(1'b1, PIF_OFS_FLAGS, {24'h0, v});
      apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, {24'h0, wexp(v)});
    end
    apb(1'b1, PIF_OFS_FLAGS, 0);
    // receive byte: flag survives a flag write, falls on buffer read
    v = 8'($urandom);
    fire('0, '{1'b1, v});
    apb(1'b1, PIF_OFS_FLAGS, 0);
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h30);
    apb(1'b0, PIF_OFS_RXBUF, 0); chk(rd, {24'h0, v});
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h10);
    // transmit byte with a slow drain
    lag <= 4'($urandom_range(15, 9));
    v = 8'($urandom);
    apb(1'b1, PIF_OFS_TXBUF, {24'h0, v});
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h00);
    chk(tx_byte, {24'h0, v});
    apb(1'b0, PIF_OFS_TXBUF, 0); chk(rd, {24'h0, v});
    repeat (30) @(posedge pclk);
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h10);
    // interrupt raised, cleared, then masked
    apb(1'b1, PIF_OFS_IRQ_ST, 32'hFF);
    apb(1'b1, PIF_OFS_IRQ_MSK, 32'h40);
    apb(1'b0, PIF_OFS_IRQ_MSK, 0); chk(rd, 32'h40);
    fire(pif_events_t'(5'h08), '0);
    chk(irq, 1);
    apb(1'b0, PIF_OFS_IRQ_ST, 0); chk(rd, 32'h40);
    apb(1'b1, PIF_OFS_IRQ_ST, 32'h40);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    apb(1'b1, PIF_OFS_IRQ_MSK, 0);
    fire(pif_events_t'(5'h08), '0);
    chk(irq, 0);
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h50);
    chk(flags, 8'h50);
    // reset in mid-run: flag view back to empty buffers, no false status edge
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PIF_OFS_FLAGS, 0); chk(rd, 32'h10);
    apb(1'b0, PIF_OFS_IRQ_ST, 0); chk(rd, 0);
    // unmapped address refused
    apb(1'b1, 12'h100, 32'hFF); chk(e, 1);
    apb(1'b0, 12'h100, 0); chk(rd, 0);
    chk(e, 1);
    summarize();
  end
endmodule : peripheral_irq_flag_register_tb
